/* File: hdl/mlsc_pkg.sv */
// Constants and types for the motion limit serial command block
package mlsc_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_HZ          = 200_000_000;
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int BAUD_RATE       = 19200;                   // 8 data, no parity, 1 stop
    localparam int BIT_CYCLES      = CLK_HZ / BAUD_RATE;      // Rounded down
    localparam int HALF_SEC_MS     = 500;
    localparam int HALF_SEC_CYCLES = HALF_SEC_MS * (CLK_HZ / 1000);
    localparam int TXD_UNIT_PS     = 4_340_000;               // 4.34 us per delay step
    localparam int TXD_UNIT_CYCLES = (TXD_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TXD_BASE_US     = 40;
    localparam int TXD_BASE_CYCLES = (TXD_BASE_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ********************************************************************
    // Command numbers (upper five bits of a command byte)
    // ********************************************************************
    localparam logic [4:0] CMD_QUERY_SPEED = 5'h03;
    localparam logic [4:0] CMD_TRAVEL      = 5'h04;
    localparam logic [4:0] CMD_REPLY_DELAY = 5'h07;
    localparam logic [4:0] CMD_SPEED_LIMIT = 5'h08;
    localparam logic [4:0] CMD_RAMP_RATE   = 5'h09;
    localparam logic [2:0] ID_BROADCAST    = 3'h0;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [15:0] SPEED_LIMIT_RST = 16'h0024;
    localparam logic [7:0]  RAMP_RATE_RST   = 8'h0F;
    localparam logic [7:0]  RAMP_RATE_MIN   = 8'h01;
    localparam logic [7:0]  REPLY_DELAY_RST = 8'h73;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } mlsc_rx_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_WAIT  = 3'b001,
        TX_START = 3'b010,
        TX_DATA  = 3'b011,
        TX_STOP  = 3'b100
    } mlsc_tx_t;

    typedef struct packed {
        logic        line_s1;
        logic        line_s2;
        logic [2:0]  id_s1;
        logic [2:0]  id_s2;
        mlsc_rx_t    rx_st;
        logic [13:0] rx_cnt;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_shift;
        logic        rx_valid;
        logic [7:0]  rx_byte;
        logic [1:0]  parse_left;
        logic [4:0]  parse_cmd;
        logic        parse_mine;
        logic [7:0]  parse_hi;
        logic [15:0] speed_limit;
        logic [7:0]  ramp_rate;
        logic [7:0]  reply_delay;
        logic [26:0] half_cnt;
        logic        half_tick;
        logic [15:0] speed_cur;
        logic [31:0] set_point;
        logic [16:0] drive;
        mlsc_tx_t    tx_st;
        logic [19:0] tx_cnt;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_shift;
        logic [7:0]  tx_lo;
        logic        tx_more;
        logic        line_out;
        logic        line_oe;
    } mlsc_state_t;

endpackage

/* File: hdl/mlsc_core.sv */
// Serial command interpreter and speed profile for a wheel position controller
`timescale 1ns/10ps
// Summary of operation
// RQ1: Speed limit command carries two bytes, high first.
// RQ2: Speed limit in positions per half second, resets 36.
// RQ3: New speed limit applies immediately.
// RQ4: Drive follows commanded minus measured wheel speed.
// RQ5: Set point advances by speed every half second.
// RQ6: Raised limit is reached by ramping.
// RQ7: Lowered limit clips current speed at once.
// RQ8: Host should change limit only while stopped.
// RQ9: Ramp rate command carries one unsigned byte.
// RQ10: Ramp rate resets to 15.
// RQ11: Accelerate to limit, brake to stop at end.
// RQ12: Ramp rate zero is replaced by one.
// RQ13: Host should change ramp rate only while stopped.
// RQ14: Frames are 19.2 kbit/s, 8N1.
// RQ15: Line released whenever not transmitting.
// RQ16: Up to four devices; answer own identifier.
// RQ17: Minimum delay before and between reply bytes.
// RQ18: Wait without timeout for all data bytes.
// RQ19: Unaddressed devices still discard data bytes.
// RQ20: Command code decides zero, one, two bytes.
// RQ21: Host never queries an absent identifier.
// RQ22: Reply delay resets 115; 4.34us steps plus 40us.
// RQ23: Command in upper five bits, identifier lower three.
// RQ24: Settings change only after complete command.
module mlsc_core #(
    parameter int BIT_CYCLES      = mlsc_pkg::BIT_CYCLES,
    parameter int HALF_SEC_CYCLES = mlsc_pkg::HALF_SEC_CYCLES,
    parameter int TXD_BASE_CYCLES = mlsc_pkg::TXD_BASE_CYCLES
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_data_in,
    input  wire logic [2:0]  i_dev_id,
    input  wire logic [15:0] i_dist_to_go,
    input  wire logic [15:0] i_wheel_speed,
    output logic             o_data_out,
    output logic             o_data_oe,
    output logic [15:0]      o_speed_cur,
    output logic [31:0]      o_set_point,
    output logic [16:0]      o_drive
);

    // ********************************************************************
    // State and derived values
    // ********************************************************************
    mlsc_pkg::mlsc_state_t cur;
    mlsc_pkg::mlsc_state_t nxt;
    logic [19:0]           wait_cyc;

    // Reply gap: setting times the unit step plus the fixed base [RQ22]
    assign wait_cyc = 20'({12'h000, cur.reply_delay} * 20'(mlsc_pkg::TXD_UNIT_CYCLES))
                    + 20'(TXD_BASE_CYCLES);

    // Data bytes that follow each command code [RQ20]
    function automatic logic [1:0] mlsc_data_count(input logic [4:0] cmd);
        logic [1:0] n;
        n = 2'h0;
        case (cmd)
            mlsc_pkg::CMD_TRAVEL:      n = 2'h2;
            mlsc_pkg::CMD_SPEED_LIMIT: n = 2'h2;
            mlsc_pkg::CMD_REPLY_DELAY: n = 2'h1;
            mlsc_pkg::CMD_RAMP_RATE:   n = 2'h1;
            default:                   n = 2'h0;
        endcase
        return n;
    endfunction

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        logic [31:0] brake_lhs;
        logic [31:0] brake_rhs;
        logic [16:0] speed_up;
        logic        my_id;
        brake_lhs = 32'h0000_0000;
        brake_rhs = 32'h0000_0000;
        speed_up  = 17'h0_0000;
        my_id     = 1'b0;
        nxt       = cur;
        nxt.rx_valid  = 1'b0;
        nxt.half_tick = 1'b0;

        // Two-stage synchronisers for the line and the identifier straps
        nxt.line_s1 = i_data_in;
        nxt.line_s2 = cur.line_s1;
        nxt.id_s1   = i_dev_id;
        nxt.id_s2   = cur.id_s1;

        // Receiver, mid-bit sampling; own transmissions are not heard [RQ14]
        nxt.rx_cnt = cur.rx_cnt + 14'h0001;
        unique case (cur.rx_st)
            mlsc_pkg::RX_IDLE: begin
                nxt.rx_cnt = 14'h0000;
                if (!cur.line_s2 && !cur.line_oe) begin
                    nxt.rx_st = mlsc_pkg::RX_START;
                end
            end
            mlsc_pkg::RX_START: begin
                if (cur.rx_cnt == 14'(BIT_CYCLES / 2)) begin
                    nxt.rx_cnt = 14'h0000;
                    nxt.rx_bit = 3'h0;
                    nxt.rx_st  = cur.line_s2 ? mlsc_pkg::RX_IDLE : mlsc_pkg::RX_DATA;
                end
            end
            mlsc_pkg::RX_DATA: begin
                if (cur.rx_cnt == 14'(BIT_CYCLES - 1)) begin
                    nxt.rx_cnt   = 14'h0000;
                    nxt.rx_shift = {cur.line_s2, cur.rx_shift[7:1]};
                    nxt.rx_bit   = cur.rx_bit + 3'h1;
                    if (cur.rx_bit == 3'h7) begin
                        nxt.rx_st = mlsc_pkg::RX_STOP;
                    end
                end
            end
            mlsc_pkg::RX_STOP: begin
                if (cur.rx_cnt == 14'(BIT_CYCLES - 1)) begin
                    // A bad stop bit drops the byte rather than desynchronising
                    nxt.rx_valid = cur.line_s2;
                    nxt.rx_byte  = cur.rx_shift;
                    nxt.rx_st    = mlsc_pkg::RX_IDLE;
                end
            end
        endcase

        // Command parser; no timeout while data bytes are awaited [RQ18]
        if (cur.rx_valid) begin
            if (cur.parse_left == 2'h0) begin
                // Command number high, identifier low; zero reaches all [RQ23] [RQ16]
                my_id = (cur.rx_byte[2:0] == cur.id_s2);
                nxt.parse_cmd  = cur.rx_byte[7:3];
                nxt.parse_mine = my_id || (cur.rx_byte[2:0] == mlsc_pkg::ID_BROADCAST);
                // Counted for every device, addressed or not [RQ19] [RQ20]
                nxt.parse_left = mlsc_data_count(cur.rx_byte[7:3]);
                // Broadcast queries would collide, so only the owner answers
                if (cur.rx_byte[7:3] == mlsc_pkg::CMD_QUERY_SPEED && my_id
                        && cur.tx_st == mlsc_pkg::TX_IDLE) begin
                    nxt.tx_st    = mlsc_pkg::TX_WAIT;
                    nxt.tx_cnt   = 20'h0_0000;
                    nxt.tx_shift = cur.speed_cur[15:8];
                    nxt.tx_lo    = cur.speed_cur[7:0];
                    nxt.tx_more  = 1'b1;
                end
            end else begin
                nxt.parse_left = cur.parse_left - 2'h1;
                if (cur.parse_left == 2'h2) begin
                    nxt.parse_hi = cur.rx_byte;                  // High byte first [RQ1]
                end
                // Settings move only when the last byte lands [RQ24]
                if (cur.parse_left == 2'h1 && cur.parse_mine) begin
                    unique case (cur.parse_cmd)
                        mlsc_pkg::CMD_SPEED_LIMIT: begin
                            nxt.speed_limit = {cur.parse_hi, cur.rx_byte};  // [RQ1] [RQ3]
                        end
                        mlsc_pkg::CMD_RAMP_RATE: begin
                            nxt.ramp_rate = (cur.rx_byte == 8'h00) ?
                                mlsc_pkg::RAMP_RATE_MIN : cur.rx_byte;      // [RQ9] [RQ12]
                        end
                        mlsc_pkg::CMD_REPLY_DELAY: begin
                            nxt.reply_delay = cur.rx_byte;                  // [RQ22]
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // Half-second time base
        if (cur.half_cnt == 27'(HALF_SEC_CYCLES - 1)) begin
            nxt.half_cnt  = 27'h000_0000;
            nxt.half_tick = 1'b1;
        end else begin
            nxt.half_cnt = cur.half_cnt + 27'h000_0001;
        end

        // Speed profile: brake when v*v reaches 2*a*d, else ramp up [RQ11] [RQ6]
        brake_lhs = {16'h0000, cur.speed_cur} * {16'h0000, cur.speed_cur};
        brake_rhs = {23'h00_0000, cur.ramp_rate, 1'b0} * {16'h0000, i_dist_to_go};
        speed_up  = {1'b0, cur.speed_cur} + {9'h000, cur.ramp_rate};
        if (cur.half_tick) begin
            // Whole speed each tick keeps slow rates exact over time [RQ5]
            nxt.set_point = cur.set_point + {16'h0000, cur.speed_cur};
            if (i_dist_to_go == 16'h0000 || brake_lhs >= brake_rhs) begin
                nxt.speed_cur = (cur.speed_cur > {8'h00, cur.ramp_rate}) ?
                    cur.speed_cur - {8'h00, cur.ramp_rate} : 16'h0000;    // [RQ11]
            end else if (speed_up > {1'b0, cur.speed_limit}) begin
                nxt.speed_cur = cur.speed_limit;                          // [RQ6]
            end else begin
                nxt.speed_cur = speed_up[15:0];                           // [RQ6]
            end
        end
        // A lowered limit cuts the speed without waiting for a tick [RQ7] [RQ3]
        if (nxt.speed_cur > cur.speed_limit) begin
            nxt.speed_cur = cur.speed_limit;
        end

        // Drive effort; negative asks for reverse torque [RQ4]
        nxt.drive = {1'b0, cur.speed_cur} - {1'b0, i_wheel_speed};

        // Reply transmitter with the minimum gap before each byte [RQ17]
        nxt.tx_cnt = cur.tx_cnt + 20'h0_0001;
        unique case (cur.tx_st)
            mlsc_pkg::TX_IDLE: begin
                nxt.tx_cnt = cur.tx_cnt;
            end
            mlsc_pkg::TX_WAIT: begin
                // A byte is taken at mid stop bit, so the first gap adds that half bit back
                if (cur.tx_cnt >= wait_cyc - 20'h0_0001
                        + (cur.tx_more ? 20'(BIT_CYCLES / 2) : 20'h0_0000)) begin
                    nxt.tx_cnt = 20'h0_0000;
                    nxt.tx_st  = mlsc_pkg::TX_START;
                end
            end
            mlsc_pkg::TX_START: begin
                if (cur.tx_cnt == 20'(BIT_CYCLES - 1)) begin
                    nxt.tx_cnt = 20'h0_0000;
                    nxt.tx_bit = 3'h0;
                    nxt.tx_st  = mlsc_pkg::TX_DATA;
                end
            end
            mlsc_pkg::TX_DATA: begin
                if (cur.tx_cnt == 20'(BIT_CYCLES - 1)) begin
                    nxt.tx_cnt   = 20'h0_0000;
                    nxt.tx_bit   = cur.tx_bit + 3'h1;
                    nxt.tx_shift = {1'b1, cur.tx_shift[7:1]};
                    if (cur.tx_bit == 3'h7) begin
                        nxt.tx_st = mlsc_pkg::TX_STOP;
                    end
                end
            end
            mlsc_pkg::TX_STOP: begin
                if (cur.tx_cnt == 20'(BIT_CYCLES - 1)) begin
                    nxt.tx_cnt   = 20'h0_0000;
                    nxt.tx_more  = 1'b0;
                    nxt.tx_shift = cur.tx_lo;
                    nxt.tx_st    = cur.tx_more ? mlsc_pkg::TX_WAIT : mlsc_pkg::TX_IDLE;
                end
            end
        endcase

        // Drive the line only inside a frame, released during gaps [RQ15]
        nxt.line_oe  = (nxt.tx_st == mlsc_pkg::TX_START) || (nxt.tx_st == mlsc_pkg::TX_DATA)
                    || (nxt.tx_st == mlsc_pkg::TX_STOP);
        nxt.line_out = (nxt.tx_st == mlsc_pkg::TX_DATA) ? nxt.tx_shift[0] :
                       (nxt.tx_st != mlsc_pkg::TX_START);
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cur             <= '0;
            cur.line_s1     <= 1'b1;
            cur.line_s2     <= 1'b1;
            cur.line_out    <= 1'b1;
            cur.speed_limit <= mlsc_pkg::SPEED_LIMIT_RST;   // [RQ2]
            cur.ramp_rate   <= mlsc_pkg::RAMP_RATE_RST;     // [RQ10]
            cur.reply_delay <= mlsc_pkg::REPLY_DELAY_RST;   // [RQ22]
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from the state flops
    assign o_data_out  = cur.line_out;
    assign o_data_oe   = cur.line_oe;
    assign o_speed_cur = cur.speed_cur;
    assign o_set_point = cur.set_point;
    assign o_drive     = cur.drive;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    a_reset_defaults: assert property ( // [RQ2] [RQ10] [RQ22]
        @(posedge i_clk_sys) $rose(i_reset_n) |-> cur.speed_limit == 16'h0024
            && cur.ramp_rate == 8'h0F && cur.reply_delay == 8'h73)
        else $error("Configuration not at power-up defaults");

    a_limit_load: assert property ( // [RQ1] [RQ3] [RQ24]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cur.rx_valid && cur.parse_left == 2'h1 && cur.parse_mine
            && cur.parse_cmd == mlsc_pkg::CMD_SPEED_LIMIT
        |=> cur.speed_limit == {$past(cur.parse_hi), $past(cur.rx_byte)})
        else $error("Speed limit not loaded from the two data bytes");

    a_limit_hold: assert property ( // [RQ24]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !(cur.rx_valid && cur.parse_left == 2'h1) |=> $stable(cur.speed_limit))
        else $error("Speed limit changed outside a complete command");

    a_ramp_floor: assert property ( // [RQ12] [RQ9]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cur.rx_valid && cur.parse_left == 2'h1 && cur.parse_mine
            && cur.parse_cmd == mlsc_pkg::CMD_RAMP_RATE && cur.rx_byte == 8'h00
        |=> cur.ramp_rate == 8'h01)
        else $error("Zero ramp rate not raised to one");

    a_speed_clip: assert property ( // [RQ7]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        $changed(cur.speed_limit) |-> ##1 cur.speed_cur <= $past(cur.speed_limit))
        else $error("Speed not clipped to a lowered limit");

    a_setpoint_step: assert property ( // [RQ5]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cur.half_tick |=> cur.set_point == $past(cur.set_point) + {16'h0000, $past(cur.speed_cur)})
        else $error("Set point did not advance by the speed");

    a_ramp_step: assert property ( // [RQ6] [RQ11]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !cur.half_tick && $stable(cur.speed_limit) |=> $stable(cur.speed_cur))
        else $error("Speed changed between half-second steps");

    a_count_data: assert property ( // [RQ19] [RQ20]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cur.rx_valid && cur.parse_left == 2'h0
            && cur.rx_byte[7:3] == mlsc_pkg::CMD_SPEED_LIMIT
        |=> cur.parse_left == 2'h2)
        else $error("Speed limit command not followed by two counted bytes");

    a_reply_gap: assert property ( // [RQ17]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cur.tx_st == mlsc_pkg::TX_START && $past(cur.tx_st) == mlsc_pkg::TX_WAIT
        |-> $past(cur.tx_cnt) + 20'h0_0001 >= wait_cyc)
        else $error("Reply byte sent before the minimum delay");

    a_line_release: assert property ( // [RQ15]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        cur.tx_st == mlsc_pkg::TX_IDLE || cur.tx_st == mlsc_pkg::TX_WAIT |-> !o_data_oe)
        else $error("Line driven outside a reply frame");

endmodule // mlsc_core

/* File: tb/mlsc_host.sv */
// Host model that sends frames on the shared serial wire and listens for replies
`timescale 1ns/10ps
module mlsc_host #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic i_clk_sys,
    input  wire logic i_line,
    output logic      o_drive_low
);
    // ****************************************************************
    // Host side of the wire
    // ****************************************************************
    // Released between frames, so the pull-up alone holds the wire high
    initial o_drive_low = 1'b0;

    // Start bit, eight data bits LSB first, one stop bit, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk_sys);
            o_drive_low = ~fr[i];
            repeat (BIT_CYCLES - 1) @(negedge i_clk_sys);
        end
    endtask

    // Waits a bounded time for a start bit, then samples mid-bit
    task automatic recv_byte(input int lim, output logic [7:0] b, output logic stp,
                             output int gap);
        b = 8'h00;
        gap = 0;
        while (i_line !== 1'b0 && gap < lim) begin
            @(negedge i_clk_sys);
            gap++;
        end
        repeat (BIT_CYCLES / 2) @(negedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(negedge i_clk_sys);
            b[i] = i_line;
        end
        repeat (BIT_CYCLES) @(negedge i_clk_sys);
        stp = i_line;
        // Return at the end of the stop bit, so the next gap counts from there
        repeat (BIT_CYCLES / 2) @(negedge i_clk_sys);
    endtask
endmodule // mlsc_host

/* File: tb/tb_top.sv */
// Self-checking bench for the motion limit serial command block
`timescale 1ns/10ps
module tb_top;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int BITC = 16;
    localparam int TXD_BASE = 40;
    logic        i_clk_sys     = 1'b0;
    logic        i_reset_n     = 1'b0;
    logic [15:0] i_dist_to_go  = 16'hFFFF;
    logic [15:0] i_wheel_speed = 16'h0000;
    logic        o_data_out;
    logic        o_data_oe;
    logic        host_low;
    logic [15:0] o_speed_cur;
    logic [31:0] o_set_point;
    logic [16:0] o_drive;
    int          n_fail        = 0;
    int          cmp_count     = 0;
    // Pulled-up wire: the device wins while it drives, else the host
    wire         line          = o_data_oe ? o_data_out : ~host_low;

    // Short counts keep the run brief; expectations follow these values
    always #2.5 i_clk_sys = ~i_clk_sys;
    mlsc_core #(.BIT_CYCLES(BITC), .HALF_SEC_CYCLES(200), .TXD_BASE_CYCLES(TXD_BASE)) dut (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_data_in     (line),
        .i_dev_id      (3'h1),
        .i_dist_to_go  (i_dist_to_go),
        .i_wheel_speed (i_wheel_speed),
        .o_data_out    (o_data_out),
        .o_data_oe     (o_data_oe),
        .o_speed_cur   (o_speed_cur),
        .o_set_point   (o_set_point),
        .o_drive       (o_drive)
    );
    mlsc_host #(.BIT_CYCLES(BITC)) host (
        .i_clk_sys   (i_clk_sys),
        .i_line      (line),
        .o_drive_low (host_low)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Bounded wait for the profile to reach a value; a skipped value fails
    task automatic wait_speed(input logic [15:0] exp, input int lim);
        int n;
        n = 0;
        while (o_speed_cur !== exp && n < lim) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk("speed reached", {16'h0, exp}, {16'h0, o_speed_cur});
        if (n >= lim) stop_test();
    endtask

    task automatic send_cmd(input logic [23:0] b, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            host.send_byte(b[i*8 +: 8]);
        end
        repeat (2) @(negedge i_clk_sys);
    endtask

    task automatic chk_speed(input string nm, input logic [15:0] exp);
        chk(nm, {16'h0, exp}, {16'h0, o_speed_cur});
    endtask

    task automatic rx_chk(input logic [7:0] exp, input int min_gap);
        logic [7:0] b;
        logic       stp;
        int         gap;
        host.recv_byte(2000, b, stp, gap);
        chk("reply byte", {24'h0, exp}, {24'h0, b});
        chk("reply delay", 32'h1, (gap >= min_gap) ? 32'h1 : 32'h0);
        chk("reply stop bit", 32'h1, {31'h0, stp});
        if (gap >= 2000) stop_test();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        chk("oe in reset", 32'h0, {31'h0, o_data_oe});
        chk_speed("speed in reset", 16'h0000);
        i_reset_n = 1'b1;
        wait_speed(16'h000F, 300);
        wait_speed(16'h001E, 300);
        wait_speed(16'h0024, 300);
        repeat (400) @(negedge i_clk_sys);
        chk_speed("speed held at default", 16'h0024);
    endtask

    task automatic t_profile();
        logic [31:0] p;
        int          n;
        p = o_set_point;
        for (n = 0; n < 300 && o_set_point === p; n++) @(negedge i_clk_sys);
        p = o_set_point;
        for (n = 0; n < 300 && o_set_point === p; n++) @(negedge i_clk_sys);
        chk("set point step", p + 32'h24, o_set_point);
        i_wheel_speed = 16'h0032;
        repeat (3) @(negedge i_clk_sys);
        chk("drive reverse", 32'h1FFF2, {15'h0, o_drive});
        i_wheel_speed = 16'h000A;
        repeat (3) @(negedge i_clk_sys);
        chk("drive forward", 32'h1A, {15'h0, o_drive});
    endtask

    task automatic t_limit();
        send_cmd(24'h410064, 3);
        wait_speed(16'h0033, 300);
        wait_speed(16'h0064, 2000);
        send_cmd(24'h410014, 3);
        chk_speed("speed clipped", 16'h0014);
    endtask

    // Zero ramp must act as one: the next two steps are single units
    task automatic t_ramp();
        send_cmd(24'h004900, 2);
        send_cmd(24'h41001E, 3);
        wait_speed(16'h0015, 300);
        wait_speed(16'h0016, 300);
    endtask

    // Data of a foreign command looks like a command on purpose
    task automatic t_address();
        wait_speed(16'h001E, 3000);
        send_cmd(24'h420005, 3);
        chk_speed("other id ignored", 16'h001E);
        send_cmd(24'h424100, 3);
        send_cmd(24'h41000A, 3);
        chk_speed("foreign bytes skipped", 16'h000A);
        // Travel data that looks like a limit command must be skipped as well
        send_cmd(24'h214100, 3);
        send_cmd(24'h400006, 3);
        chk_speed("broadcast applied", 16'h0006);
        send_cmd(24'h004100, 2);
        repeat (1000) @(negedge i_clk_sys);
        chk_speed("partial command", 16'h0006);
        send_cmd(24'h000005, 1);
        chk_speed("late data byte", 16'h0005);
    endtask

    task automatic t_query();
        send_cmd(24'h0049FF, 2);
        send_cmd(24'h410123, 3);
        wait_speed(16'h0123, 600);
        send_cmd(24'h003900, 2);
        host.send_byte(8'h19);
        // First gap counts from the host's last stop-bit cycle, hence two more
        rx_chk(8'h01, TXD_BASE + 2);
        rx_chk(8'h23, TXD_BASE);
        repeat (BITC) @(negedge i_clk_sys);
        chk("line released", 32'h0, {31'h0, o_data_oe});
    endtask

    task automatic t_stop();
        logic [31:0] p;
        i_dist_to_go = 16'h0000;
        wait_speed(16'h0000, 600);
        p = o_set_point;
        repeat (400) @(negedge i_clk_sys);
        chk("set point at rest", p, o_set_point);
        // Settings changed only at rest, then a fresh ramp from standstill
        send_cmd(24'h004903, 2);
        send_cmd(24'h410009, 3);
        i_dist_to_go = 16'hFFFF;
        wait_speed(16'h0003, 300);
        wait_speed(16'h0006, 300);
        wait_speed(16'h0009, 300);
    endtask

    // Main sequence: reset held for 8 cycles, then each scenario in turn
    initial begin
        repeat (8) @(negedge i_clk_sys);
        t_defaults();
        t_profile();
        t_limit();
        t_ramp();
        t_address();
        t_query();
        t_stop();
        stop_test();
    end
endmodule // tb_top
